// File: src/fis_regs.vh
`ifndef FIS_REGS_VH
`define FIS_REGS_VH
`define FIS_ADDR_CMD 8'hd5
`define FIS_ADDR_DATA 8'hd6
`define FIS_BIT_IDLE 7
`define FIS_BIT_ERR 6
`define FIS_CMD_READ 4'h0
`define FIS_CMD_VFY_OPT 4'h1
`define FIS_CMD_VFY_SEC 4'h2
`define FIS_CMD_VFY_BANK 4'h3
`define FIS_CMD_PRG_OPT 4'h9
`define FIS_CMD_PRG_SEC 4'ha
`define FIS_CMD_PRG_BANK 4'hb
`define FIS_CMD_ERS_OPT 4'hc
`define FIS_CMD_ERS_SEC 4'hd
`define FIS_CMD_ERS_BANK 4'he
`define FIS_CMD_SYS_RST 4'hf
`define FIS_BANK_HI_MIN 8'h20
`define FIS_BANK_HI_MAX 8'h3f
`define FIS_ERASED 8'hff
`define FIS_LOCK_ADDR 6'h00
`define FIS_MC_CYCLES 3'h4
`define FIS_BUSY_DELAY 8'h0a
`endif

// File: src/fis_mc_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "fis_regs.vh"
module fis_mc_tick (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // one-cycle machine-cycle enable
  output reg tick
);
  reg [2:0] count;
  // a machine cycle is four system clocks
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 3'h0;
      tick <= 1'b0;
    end else if (count == `FIS_MC_CYCLES - 3'h1) begin
      count <= 3'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 3'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: src/fis_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "fis_regs.vh"
module fis_seq (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // special function register access from the core
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire timed_access_ok,
  output reg [7:0] sfr_rdata,
  // flash array self-timed engine
  output reg flash_start,
  output reg [3:0] flash_op,
  output reg [13:0] flash_addr,
  output reg [7:0] flash_wdata,
  input wire flash_done,
  input wire flash_fail,
  // system side
  output reg upper_bank_exec_ok,
  output reg system_reset_req
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [3:0] command_code_field;
  reg sequencer_idle_flag;
  reg operation_failure_flag;
  reg [7:0] data_port;
  reg [1:0] byte_count;
  reg [7:0] addr_hi;
  reg [7:0] addr_lo;
  reg running;
  reg pend_read;
  reg [7:0] option_byte;
  reg [7:0] sec_mem [0:63];
  reg [7:0] bank_mem [0:8191];
  reg [7:0] delay;
  wire mc_tick;
  integer i;

  fis_mc_tick u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .tick(mc_tick)
  );

  wire wr_cmd = sfr_wr && sfr_addr == `FIS_ADDR_CMD;
  wire loaded = command_code_field != `FIS_CMD_READ;
  wire wr_data = sfr_wr && sfr_addr == `FIS_ADDR_DATA && loaded && !running;
  // upper bank only: address high byte must fall in 20h..3fh
  wire bank_ok = addr_hi >= `FIS_BANK_HI_MIN && addr_hi <= `FIS_BANK_HI_MAX;
  wire [12:0] bank_idx = {addr_hi[4:0], addr_lo};

  // ----------------------------------------
  // command register
  // ----------------------------------------
  // timed access only, and ignored while a job runs; lock bits never consulted
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      command_code_field <= `FIS_CMD_READ;
    end else if (wr_cmd && timed_access_ok && !running) begin
      command_code_field <= sfr_wdata[3:0];
    end
  end

  // upper bank executable only in read mode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_bank_exec_ok <= 1'b1;
      system_reset_req <= 1'b0;
    end else begin
      upper_bank_exec_ok <= !loaded;
      system_reset_req <= command_code_field == `FIS_CMD_SYS_RST;
    end
  end

  // ----------------------------------------
  // data port sequencing
  // ----------------------------------------
  // bytes counted per command; a new command restarts the count, but the 2-bit count wraps,
  // so bytes written after the job ends are still taken and can start another operation
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_count <= 2'h0;
      addr_hi <= 8'h00;
      addr_lo <= 8'h00;
      data_port <= 8'h00;
      running <= 1'b0;
      pend_read <= 1'b0;
      sequencer_idle_flag <= 1'b1;
      operation_failure_flag <= 1'b0;
      flash_start <= 1'b0;
      flash_op <= 4'h0;
      flash_addr <= 14'h0000;
      flash_wdata <= 8'h00;
      delay <= 8'h00;
      option_byte <= `FIS_ERASED;
    end else begin
      flash_start <= 1'b0;
      if (wr_cmd && timed_access_ok && !running) begin
        byte_count <= 2'h0;
        pend_read <= sfr_wdata[3:0] == `FIS_CMD_VFY_OPT;
        operation_failure_flag <= 1'b0;
      end else if (wr_data) begin
        data_port <= sfr_wdata;
        byte_count <= byte_count + 2'h1;
        if (byte_count == 2'h0) begin
          addr_hi <= sfr_wdata;
        end
        if (byte_count == 2'h1) begin
          addr_lo <= sfr_wdata;
        end
        case (command_code_field)
          `FIS_CMD_VFY_SEC: begin
            addr_hi <= sfr_wdata;
            pend_read <= byte_count == 2'h0;
          end
          `FIS_CMD_VFY_BANK: pend_read <= byte_count == 2'h1;
          `FIS_CMD_PRG_OPT: begin
            if (byte_count == 2'h0) begin
              running <= 1'b1;
              flash_wdata <= sfr_wdata;
            end
          end
          `FIS_CMD_PRG_SEC: begin
            if (byte_count == 2'h1) begin
              running <= 1'b1;
              flash_wdata <= sfr_wdata;
            end
          end
          `FIS_CMD_PRG_BANK: begin
            if (byte_count == 2'h2) begin
              running <= 1'b1;
              flash_wdata <= sfr_wdata;
            end
          end
          default: ;
        endcase
      end else if (mc_tick && pend_read) begin
        // verify answers land at the end of the current machine cycle
        pend_read <= 1'b0;
        case (command_code_field)
          `FIS_CMD_VFY_OPT: data_port <= option_byte;
          `FIS_CMD_VFY_SEC: data_port <= sec_mem[addr_hi[5:0]];
          `FIS_CMD_VFY_BANK: data_port <= bank_ok ? bank_mem[bank_idx] : `FIS_ERASED;
          default: ;
        endcase
      end
      // erase commands need no data bytes: start on load
      if (wr_cmd && timed_access_ok && !running &&
          sfr_wdata[3:0] >= `FIS_CMD_ERS_OPT && sfr_wdata[3:0] <= `FIS_CMD_ERS_BANK) begin
        running <= 1'b1;
      end
      // job launch and completion; idle falls a few cycles after the request
      if (running) begin
        if (delay != `FIS_BUSY_DELAY) begin
          delay <= delay + 8'h01;
          if (delay == 8'h00) begin
            // a lower-bank target never reaches the array; it fails at the end of the delay
            flash_start <= !(command_code_field == `FIS_CMD_PRG_BANK && !bank_ok);
            flash_op <= command_code_field;
            flash_addr <= {addr_hi[5:0], addr_lo};
          end
          if (delay == `FIS_BUSY_DELAY - 8'h01) begin
            sequencer_idle_flag <= 1'b0;
          end
        end else if (flash_fail || (command_code_field == `FIS_CMD_PRG_BANK && !bank_ok)) begin
          running <= 1'b0;
          delay <= 8'h00;
          sequencer_idle_flag <= 1'b1;
          operation_failure_flag <= 1'b1;
        end else if (flash_done) begin
          running <= 1'b0;
          delay <= 8'h00;
          sequencer_idle_flag <= 1'b1;
          if (command_code_field == `FIS_CMD_PRG_OPT) begin
            option_byte <= flash_wdata;
          end
          if (command_code_field == `FIS_CMD_ERS_OPT) begin
            option_byte <= `FIS_ERASED;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // array image
  // ----------------------------------------
  // mirror of the array for verify reads; not reset, contents are nonvolatile
  always @(posedge clk) begin
    if (running && delay == `FIS_BUSY_DELAY && flash_done && !flash_fail) begin
      case (command_code_field)
        `FIS_CMD_PRG_SEC: sec_mem[addr_hi[5:0]] <= flash_wdata;
        `FIS_CMD_PRG_BANK: if (bank_ok) bank_mem[bank_idx] <= flash_wdata;
        `FIS_CMD_ERS_SEC: for (i = 0; i < 64; i = i + 1) sec_mem[i] <= `FIS_ERASED;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // flags read-only; data port reads zero when no command is loaded
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == `FIS_ADDR_CMD) begin
      sfr_rdata <= {sequencer_idle_flag, operation_failure_flag, 2'b00,
                    command_code_field};
    end else if (sfr_rd && sfr_addr == `FIS_ADDR_DATA) begin
      sfr_rdata <= loaded ? data_port : 8'h00;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// File: verif/fis_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fis_flash_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // engine handshake
  input wire logic flash_start,
  input wire logic fail_mode,
  output logic flash_done,
  output logic flash_fail
);
  logic [4:0] cnt;
  // answers 20 clocks after launch, so the idle flag can be seen low first
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 5'h00;
      flash_done <= 1'b0;
      flash_fail <= 1'b0;
    end else begin
      cnt <= flash_start ? 5'h14 : (cnt != 5'h00 ? cnt - 5'h01 : 5'h00);
      flash_done <= cnt == 5'h01 && !fail_mode;
      flash_fail <= cnt == 5'h01 && fail_mode;
    end
  end
endmodule
`default_nettype wire

// File: verif/fis_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fis_seq_checker (
  // watched ports
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic timed_access_ok,
  input wire logic [7:0] sfr_rdata,
  input wire logic flash_start,
  input wire logic [3:0] flash_op,
  input wire logic [13:0] flash_addr,
  input wire logic flash_done,
  input wire logic flash_fail,
  input wire logic upper_bank_exec_ok,
  input wire logic system_reset_req
);
  logic busy;
  logic [4:0] age;
  wire ta_wr = sfr_wr && timed_access_ok && sfr_addr == 8'hd5;
  wire cmd_wr = ta_wr && !busy && !flash_start;
  wire st_rd = sfr_rd && sfr_addr == 8'hd5;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // busy as seen on the engine pins; misses the launch cycle, benign here
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      busy <= 1'b0;
    else
      busy <= flash_start | (busy & !flash_done & !flash_fail);
  end
  // age saturates so it never wraps back into the window
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      age <= 5'h00;
    else if (flash_start)
      age <= 5'h00;
    else if (age != 5'h1f)
      age <= age + 5'h01;
  end
  sequence s_done_poll;
    flash_done ##2 st_rd;
  endsequence
  sequence s_fail_poll;
    flash_fail ##2 st_rd;
  endsequence
  a_start_one_clk: assert property (flash_start |=> !flash_start) else $error("long start");
  a_idle_low: assert property (busy && age >= 5'h0a && st_rd |=> !sfr_rdata[7])
    else $error("idle high while busy");
  a_idle_back: assert property (s_done_poll |=> sfr_rdata[7]) else $error("idle stuck");
  a_fail_flags: assert property (s_fail_poll |=> sfr_rdata[7:6] == 2'b11)
    else $error("fail flags");
  a_bank_range: assert property (flash_start && flash_op == 4'hb |-> flash_addr[13])
    else $error("lower bank");
  a_erase_go: assert property (cmd_wr && sfr_wdata[3:0] == 4'he |-> ##[1:2]
    (flash_start && flash_op == 4'he)) else $error("erase late");
  a_sys_reset: assert property (cmd_wr && sfr_wdata[3:0] == 4'hf |-> ##2 system_reset_req)
    else $error("no reset");
  a_exec_gate: assert property (system_reset_req |-> !upper_bank_exec_ok)
    else $error("exec open");
  a_busy_ignore: assert property (busy && ta_wr |=> $stable(system_reset_req))
    else $error("cmd taken busy");
endmodule
`default_nettype wire

// File: verif/fis_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fis_seq_tb;
  logic clk, reset_n, sfr_wr, sfr_rd, timed_access_ok, fail_mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, flash_wdata, d;
  logic [3:0] flash_op;
  logic [13:0] flash_addr;
  logic flash_start, flash_done, flash_fail, upper_bank_exec_ok, system_reset_req;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  fis_seq fis_seq_i (.*);
  fis_flash_model fis_flash_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // one strobe per call; the gap cycle keeps strobes from merging
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic ta);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = v;
    timed_access_ok = ta;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    timed_access_ok = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  task automatic wait_start;
    for (int n = 0; n < 40 && !flash_start; n++) @(negedge clk);
  endtask
  // the flags update one edge after the engine answers, so let that edge pass
  task automatic wait_eng;
    for (int n = 0; n < 60 && !(flash_done | flash_fail); n++) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset_state;
    rd(8'hd5);
    check(d, 8'h80);
    check({7'h00, upper_bank_exec_ok}, 8'h01);
    rd(8'hd6);
    check(d, 8'h00);
  endtask
  task automatic t_prog_bank;
    wr(8'hd5, 8'h0b, 1'b1);
    wr(8'hd6, 8'h21, 1'b0);
    wr(8'hd6, 8'h34, 1'b0);
    wr(8'hd6, 8'h5a, 1'b0);
    wait_start;
    check({4'h0, flash_op}, 8'h0b);
    check({flash_addr[13:8], flash_addr[7:6]}, 8'h84);
    check(flash_wdata, 8'h5a);
    repeat (10) @(negedge clk);
    rd(8'hd5);
    check(d & 8'hc0, 8'h00);
    check({7'h00, upper_bank_exec_ok}, 8'h00);
    wait_eng;
    rd(8'hd5);
    check(d, 8'h8b);
    wr(8'hd5, 8'h00, 1'b1);
    repeat (2) @(negedge clk);
    check({7'h00, upper_bank_exec_ok}, 8'h01);
  endtask
  task automatic t_bad_bank;
    wr(8'hd5, 8'h0b, 1'b1);
    wr(8'hd6, 8'h10, 1'b0);
    wr(8'hd6, 8'h00, 1'b0);
    wr(8'hd6, 8'h77, 1'b0);
    repeat (40) @(negedge clk);
    rd(8'hd5);
    check(d & 8'hc0, 8'hc0);
    wr(8'hd5, 8'h00, 1'b1);
  endtask
  task automatic t_erase_fail;
    fail_mode = 1'b1;
    wr(8'hd5, 8'h0e, 1'b1);
    wait_start;
    check({4'h0, flash_op}, 8'h0e);
    wr(8'hd5, 8'h0f, 1'b1);
    check({7'h00, system_reset_req}, 8'h00);
    wait_eng;
    rd(8'hd5);
    check(d & 8'hc0, 8'hc0);
    fail_mode = 1'b0;
    wr(8'hd5, 8'h00, 1'b1);
  endtask
  // reserved codes are never sent
  task automatic t_cmd_codes;
    wr(8'hd5, 8'h0f, 1'b0);
    repeat (2) @(negedge clk);
    check({7'h00, system_reset_req}, 8'h00);
    wr(8'hd5, 8'h01, 1'b1);
    repeat (5) @(negedge clk);
    rd(8'hd6);
    check(d, 8'hff);
    wr(8'hd5, 8'h0f, 1'b1);
    repeat (2) @(negedge clk);
    check({7'h00, system_reset_req}, 8'h01);
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    check({7'h00, system_reset_req}, 8'h00);
  endtask
  task automatic give_verdict;
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard, far above the fewer than two hundred clocks the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      give_verdict;
    end
  end
  initial begin
    reset_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    timed_access_ok = 1'b0;
    fail_mode = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    t_reset_state;
    t_prog_bank;
    t_bad_bank;
    t_erase_fail;
    t_cmd_codes;
    give_verdict;
  end
endmodule
bind fis_seq fis_seq_checker fis_seq_checker_i (.*);
`default_nettype wire
